// ===== src/cmp_pkg.sv
/*
  Constants for the compare-match PWM stage: register indices, reset
  values, field positions and encodings.
  Assumes byte address = 4 x register index on an AXI4-Lite bus.
*/
package cmp_pkg;
  localparam int ADDR_W = 12;
  localparam int IDX_W = 10;
  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_MODE = 10'h120;
  localparam logic [IDX_W-1:0] IDX_CCR1 = 10'h121;
  localparam logic [IDX_W-1:0] IDX_STAT = 10'h123;
  localparam logic [IDX_W-1:0] IDX_IOR0 = 10'h124;
  localparam logic [IDX_W-1:0] IDX_IOR1 = 10'h125;
  localparam logic [IDX_W-1:0] IDX_CNT = 10'h126;
  localparam logic [IDX_W-1:0] IDX_GRA = 10'h128;
  // Reset values
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_CCR1 = 8'h00;
  localparam logic [7:0] RST_IOR = 8'h88;
  localparam logic [15:0] RST_GR = 16'hFFFF;
  localparam logic [15:0] RST_CNT = 16'h0000;
  // Bits that always read as one
  localparam logic [7:0] ONES_IOR0 = 8'h80;
  localparam logic [7:0] ONES_IOR1 = 8'h88;
  // Mode register fields
  localparam int MODE_BFC = 4;
  localparam int MODE_BFD = 5;
  localparam int MODE_RUN = 7;
  // Counter control fields
  localparam int CCR1_SRC_LO = 4;
  localparam int CCR1_CLEAR_ON_PERIOD_MATCH = 7;
  // I/O control fields
  localparam int IOR_ACT_LO = 0;
  localparam int IOR_MODE_LO = 2;
  localparam int IOR_ACT_HI = 4;
  localparam int IOR_MODE_HI = 6;
  localparam int STAT_W = 5;
  localparam int DIV_W = 5;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    SRC_F1 = 3'b000, SRC_F2 = 3'b001, SRC_F4 = 3'b010, SRC_F8 = 3'b011,
    SRC_F32 = 3'b100, SRC_EXT = 3'b101, SRC_OSC = 3'b110, SRC_RSV = 3'b111
  } cmp_src_e;
  typedef enum logic [1:0] {
    ACT_NONE = 2'b00, ACT_LOW = 2'b01, ACT_HIGH = 2'b10, ACT_TOGGLE = 2'b11
  } cmp_act_e;
endpackage : cmp_pkg

// ===== src/cmp_pwm_top.sv
/*
  Compare-match and PWM waveform stage of a 16-bit timer with an
  AXI4-Lite register slave.
  Assumes ext and oscillator inputs are synchronous to clk.
*/
// The AXI4-Lite register port is this design's own decision.
// How it works
// - Channel C action field: none, low, high or toggle on C match.
// - Channel D action field bits 5:4, same encoding, on D match.
// - Bits 3 and 7 of the C/D control register read as one.
// - Initial-level bits give each pin its level until first match.
// - Count source: f1,f2,f4,f8,f32, ext rising edge, fast osc.
// - Clear-select 0 free-runs outside PWM; 1 or any PWM mode clears counter on A match.
// - Writing counter control drives waveform pins to initial level.
// - Compare regs A..D drive pins A..D, C/D when unbuffered.
// - Buffered C feeds next A value; buffered D feeds next B.
// - PWM on pins B,C,D; A sets period, pin A not driven.
// - PWM period m+1, inactive n+1, active m-n cycles.
// - Run bit starts and stops; pins and counter hold on stop.
// - Match on A..D and counter overflow raise request flags.
// - Counter readable and writable by software at any time.
// - PWM active level chosen per pin, opposite to initial level.
// - PWM: buffered C holds next period, buffered D next B point.
// - PWM: B, unbuffered C and D hold change points.
// - Change point equal to period never alters the pin.
// - Free-running counter wraps after 65,536 ticks.
// - Channels A and B share the four-way action encoding.
// - On stop compare pins keep level and counter keeps value.
`timescale 1ns/100ps
module cmp_pwm_top
  import cmp_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic extCountInput,
  input wire logic fastOnchipOscClock,
  output logic wavePinA,
  output logic wavePinB,
  output logic wavePinC,
  output logic wavePinD,
  output logic wavePinAOe,
  output logic wavePinBOe,
  output logic wavePinCOe,
  output logic wavePinDOe,
  output logic [STAT_W-1:0] matchFlags
);

  function automatic logic isMapped(input logic [IDX_W-1:0] idx);
    isMapped = (idx == IDX_MODE) || (idx == IDX_CCR1) || (idx == IDX_STAT) ||
      (idx == IDX_IOR0) || (idx == IDX_IOR1) || (idx == IDX_CNT) ||
      (idx >= IDX_GRA && idx <= IDX_GRA + 10'h003);
  endfunction : isMapped

  function automatic logic [15:0] merge16(input logic [15:0] old,
    input logic [31:0] data, input logic [3:0] strb);
    merge16 = old;
    if (strb[0])
      merge16[7:0] = data[7:0];
    if (strb[1])
      merge16[15:8] = data[15:8];
  endfunction : merge16

  function automatic logic applyAct(input logic [1:0] act, input logic cur);
    case (act)
      ACT_LOW: applyAct = 1'b0;
      ACT_HIGH: applyAct = 1'b1;
      ACT_TOGGLE: applyAct = ~cur;
      default: applyAct = cur;
    endcase
  endfunction : applyAct

  logic awHave_q, wHave_q, awReady_q, wReady_q, bValid_q, arReady_q, rValid_q;
  logic [1:0] bResp_q, rResp_q;
  logic [31:0] rData_q, wData_q, rdMux;
  logic [3:0] wStrb_q;
  logic [IDX_W-1:0] wIdx_q, rIdx;
  logic awHaveD, wHaveD, rValidD, wrGo;
  logic [7:0] mode_q, ccr1_q, ior0_q, ior1_q;
  logic [STAT_W-1:0] stat_q, events;
  logic [15:0] cnt_q;
  logic [15:0] gr_q [4];
  logic [DIV_W-1:0] div_q;
  logic extPrev_q, oscPrev_q, tick, run, anyPwm, clrOnA, clrNow;
  logic wrMode, wrCcr1, wrStat, wrIor0, wrIor1, wrCnt;
  logic [3:0] match, init, pwmPin, ocPin, oeD, hasOwn, modeSel;
  logic [3:0] pinLvl_q, pinOe_q;
  logic [1:0] act [4];

  // Bus slave: address and data taken in either order
  assign wrGo = awHave_q & wHave_q & ~bValid_q;
  assign awHaveD = (awHave_q & ~wrGo) | (s_axi_awvalid & awReady_q);
  assign wHaveD = (wHave_q & ~wrGo) | (s_axi_wvalid & wReady_q);
  assign rValidD = (rValid_q & ~s_axi_rready) | (s_axi_arvalid & arReady_q);
  assign rIdx = s_axi_araddr[ADDR_W-1:2];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
    begin
      awHave_q <= 1'b0;
      wHave_q <= 1'b0;
      awReady_q <= 1'b0;
      wReady_q <= 1'b0;
      wIdx_q <= '0;
      wData_q <= '0;
      wStrb_q <= '0;
    end
    else
    begin
      awHave_q <= awHaveD;
      wHave_q <= wHaveD;
      awReady_q <= ~awHaveD;
      wReady_q <= ~wHaveD;
      if (s_axi_awvalid & awReady_q)
        wIdx_q <= s_axi_awaddr[ADDR_W-1:2];
      if (s_axi_wvalid & wReady_q)
      begin
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
    begin
      bValid_q <= 1'b0;
      bResp_q <= RESP_OKAY;
    end
    else if (wrGo)
    begin
      bValid_q <= 1'b1;
      bResp_q <= isMapped(wIdx_q) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      bValid_q <= 1'b0;
  end

  always_comb begin
    rdMux = '0;
    if (rIdx == IDX_MODE)
      rdMux[7:0] = mode_q;
    else if (rIdx == IDX_CCR1)
      rdMux[7:0] = ccr1_q;
    else if (rIdx == IDX_STAT)
      rdMux[STAT_W-1:0] = stat_q;
    else if (rIdx == IDX_IOR0)
      rdMux[7:0] = ior0_q | ONES_IOR0;
    else if (rIdx == IDX_IOR1)
      rdMux[7:0] = ior1_q | ONES_IOR1;
    else if (rIdx == IDX_CNT)
      rdMux[15:0] = cnt_q;
    else if (rIdx >= IDX_GRA && rIdx <= IDX_GRA + 10'h003)
      rdMux[15:0] = gr_q[rIdx[1:0]];
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
    begin
      arReady_q <= 1'b0;
      rValid_q <= 1'b0;
      rData_q <= '0;
      rResp_q <= RESP_OKAY;
    end
    else
    begin
      arReady_q <= ~rValidD;
      rValid_q <= rValidD;
      if (s_axi_arvalid & arReady_q)
      begin
        rData_q <= rdMux;
        rResp_q <= isMapped(rIdx) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  assign wrMode = wrGo & (wIdx_q == IDX_MODE) & wStrb_q[0];
  assign wrCcr1 = wrGo & (wIdx_q == IDX_CCR1) & wStrb_q[0];
  assign wrStat = wrGo & (wIdx_q == IDX_STAT) & wStrb_q[0];
  assign wrIor0 = wrGo & (wIdx_q == IDX_IOR0) & wStrb_q[0];
  assign wrIor1 = wrGo & (wIdx_q == IDX_IOR1) & wStrb_q[0];
  assign wrCnt = wrGo & (wIdx_q == IDX_CNT);

  // Control registers; counter control is not locked while running
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
    begin
      mode_q <= RST_MODE;
      ccr1_q <= RST_CCR1;
      ior0_q <= RST_IOR;
      ior1_q <= RST_IOR;
    end
    else
    begin
      if (wrMode)
        mode_q <= wData_q[7:0];
      if (wrCcr1)
        ccr1_q <= wData_q[7:0];
      if (wrIor0)
        ior0_q <= wData_q[7:0] & ~ONES_IOR0;
      if (wrIor1)
        ior1_q <= wData_q[7:0] & ~ONES_IOR1;
    end
  end

  // Count source ticks
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
    begin
      div_q <= '0;
      extPrev_q <= 1'b0;
      oscPrev_q <= 1'b0;
    end
    else
    begin
      div_q <= div_q + 5'h01;
      extPrev_q <= extCountInput;
      oscPrev_q <= fastOnchipOscClock;
    end
  end

  always_comb begin
    case (cmp_src_e'(ccr1_q[CCR1_SRC_LO +: 3]))
      SRC_F1: tick = 1'b1;
      SRC_F2: tick = &div_q[0:0];
      SRC_F4: tick = &div_q[1:0];
      SRC_F8: tick = &div_q[2:0];
      SRC_F32: tick = &div_q[4:0];
      SRC_EXT: tick = extCountInput & ~extPrev_q;
      SRC_OSC: tick = fastOnchipOscClock & ~oscPrev_q;
      default: tick = 1'b0;
    endcase
  end

  assign run = mode_q[MODE_RUN];
  assign anyPwm = |mode_q[2:0];
  assign clrOnA = ccr1_q[CCR1_CLEAR_ON_PERIOD_MATCH] | anyPwm;
  assign clrNow = tick & run & clrOnA & match[0];
  assign hasOwn = {~mode_q[MODE_BFD], ~mode_q[MODE_BFC], 2'b11};
  assign init = ccr1_q[3:0];
  assign act[0] = ior0_q[IOR_ACT_LO +: 2];
  assign act[1] = ior0_q[IOR_ACT_HI +: 2];
  assign act[2] = ior1_q[IOR_ACT_LO +: 2];
  assign act[3] = ior1_q[IOR_ACT_HI +: 2];
  assign modeSel = {ior1_q[IOR_MODE_HI], ior1_q[IOR_MODE_LO],
    ior0_q[IOR_MODE_HI], ior0_q[IOR_MODE_LO]};
  assign pwmPin = {mode_q[2:0], 1'b0} & hasOwn;
  assign events = {tick & run & (cnt_q == CNT_MAX) & ~clrNow, match};

  // Counter: a clear coinciding with a software write wins
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      cnt_q <= RST_CNT;
    else if (clrNow)
      cnt_q <= RST_CNT;
    else if (wrCnt)
      cnt_q <= merge16(cnt_q, wData_q, wStrb_q);
    else if (tick & run)
      cnt_q <= cnt_q + 16'h0001;
  end

  // Sticky flags, write 0 clears; a new event wins over the clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      stat_q <= '0;
    else if (wrStat)
      stat_q <= (stat_q & wData_q[STAT_W-1:0]) | events;
    else
      stat_q <= stat_q | events;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      matchFlags <= '0;
    else
      matchFlags <= stat_q;
  end

  genvar i;
  generate
    for (i = 0; i < 4; i++)
    begin : g_ch
      assign match[i] = tick & run & (cnt_q == gr_q[i]);
      // Pin A yields to PWM period use
      assign ocPin[i] = (act[i] != ACT_NONE) & ~modeSel[i] & hasOwn[i] &
        ~(i == 0 && anyPwm);
      assign oeD[i] = pwmPin[i] | ocPin[i];

      // Buffer transfer beats a same-cycle software write
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
          gr_q[i] <= RST_GR;
        else if (i == 0 && mode_q[MODE_BFC] && match[0])
          gr_q[i] <= gr_q[2];
        else if (i == 1 && mode_q[MODE_BFD] && match[1])
          gr_q[i] <= gr_q[3];
        else if (wrGo && wIdx_q == IDX_GRA + 10'(i))
          gr_q[i] <= merge16(gr_q[i], wData_q, wStrb_q);
      end

      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
        begin
          pinLvl_q[i] <= 1'b0;
          pinOe_q[i] <= 1'b0;
        end
        else
        begin
          pinOe_q[i] <= oeD[i];
          if (wrCcr1)
            pinLvl_q[i] <= wData_q[i];
          else if (pwmPin[i])
          begin
            // Inactive level is the initial level
            if (match[i] && gr_q[i] != gr_q[0])
              pinLvl_q[i] <= ~init[i];
            else if (match[0])
              pinLvl_q[i] <= init[i];
          end
          else if (ocPin[i] && match[i])
            pinLvl_q[i] <= applyAct(act[i], pinLvl_q[i]);
        end
      end
    end
  endgenerate

  assign s_axi_awready = awReady_q;
  assign s_axi_wready = wReady_q;
  assign s_axi_bvalid = bValid_q;
  assign s_axi_bresp = bResp_q;
  assign s_axi_arready = arReady_q;
  assign s_axi_rvalid = rValid_q;
  assign s_axi_rdata = rData_q;
  assign s_axi_rresp = rResp_q;
  assign wavePinA = pinLvl_q[0];
  assign wavePinB = pinLvl_q[1];
  assign wavePinC = pinLvl_q[2];
  assign wavePinD = pinLvl_q[3];
  assign wavePinAOe = pinOe_q[0];
  assign wavePinBOe = pinOe_q[1];
  assign wavePinCOe = pinOe_q[2];
  assign wavePinDOe = pinOe_q[3];

endmodule : cmp_pwm_top

// ===== tb/cmp_pwm_monitor.sv
/* Bus and status-flag checker for the compare PWM stage.
   Assumes it is bound to the top module ports, one clock domain. */
`timescale 1ns/100ps
module cmp_pwm_monitor
  import cmp_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [STAT_W-1:0] matchFlags
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer missing");
  chk_rd_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_rd_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  chk_rd_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready && !s_axi_bvalid |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  chk_wr_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  chk_wr_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  chk_aw_take: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("address ready stuck");
  // Flags only fall after a software write to status
  chk_flag_clear: assert property ((($past(matchFlags) & ~matchFlags) != '0)
    |-> $past(s_axi_bvalid))
    else $error("flag cleared without write");
endmodule : cmp_pwm_monitor
bind cmp_pwm_top cmp_pwm_monitor u_mon (.clk, .nrst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .matchFlags);

// ===== tb/cmp_pin_model.sv
/* Pad-side model: pull-ups on the wave pads, count pulse sources.
   Assumes pads are sampled on clk by the bench. */
`timescale 1ns/100ps
module cmp_pin_model
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [3:0] pinOut,
  input wire logic [3:0] pinOe,
  output logic extCount,
  output logic oscCount,
  output logic [3:0] padLevel
);
  logic [3:0] div_q;
  // Released pads float to the pull-up, never to a stale level
  assign padLevel = (pinOut & pinOe) | ~pinOe;
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      div_q <= 4'h0;
    else
      div_q <= div_q + 4'h1;
  assign extCount = div_q[1];
  assign oscCount = div_q[0];
endmodule : cmp_pin_model

// ===== tb/cmp_pwm_top_test.sv
/* Bench for the compare PWM stage: registers, actions, PWM, sources.
   Assumes the pad model supplies pull-ups and count inputs. */
`timescale 1ns/100ps
module cmp_pwm_top_test
  import cmp_pkg::*;
;
  logic clk, nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic extCountInput, fastOnchipOscClock, wavePinA, wavePinB, wavePinC, wavePinD;
  logic wavePinAOe, wavePinBOe, wavePinCOe, wavePinDOe;
  logic [STAT_W-1:0] matchFlags;
  logic [3:0] pad, s_axi_wstrb;
  int mismatches, checks, cyc, wrCyc;
  cmp_pwm_top i_dut (.clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .extCountInput, .fastOnchipOscClock,
    .wavePinA, .wavePinB, .wavePinC, .wavePinD, .wavePinAOe, .wavePinBOe, .wavePinCOe,
    .wavePinDOe, .matchFlags);
  cmp_pin_model i_pins (.clk, .nrst, .pinOut({wavePinD, wavePinC, wavePinB, wavePinA}),
    .pinOe({wavePinDOe, wavePinCOe, wavePinBOe, wavePinAOe}), .extCount(extCountInput),
    .oscCount(fastOnchipOscClock), .padLevel(pad));
  always @(negedge clk) cyc++;
  task automatic check(input string w, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", w, e, g);
    end
  endtask : check
  task automatic wr(input logic [9:0] i, input logic [31:0] d, input logic [1:0] er = RESP_OKAY,
    input logic [3:0] st = 4'hF);
    int n;
    logic ta, tw;
    @(posedge clk);
    wrCyc = cyc;
    s_axi_awaddr <= {i, 2'b00};
    s_axi_wdata <= d;
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    ta = 1'b0;
    tw = 1'b0;
    while (!(ta && tw) && n++ < 99)
    begin
      @(negedge clk);
      ta |= s_axi_awready;
      tw |= s_axi_wready;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    @(negedge clk);
    while (s_axi_bvalid !== 1'b1 && n++ < 99) @(negedge clk);
    // An exhausted wait is a failure in its own right
    if (n > 99) mismatches++;
    check("bresp", er, s_axi_bresp);
    @(posedge clk);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [9:0] i, input logic [1:0] er, output logic [31:0] d);
    int n;
    @(posedge clk);
    s_axi_araddr <= {i, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    @(negedge clk);
    while (s_axi_arready !== 1'b1 && n++ < 99) @(negedge clk);
    @(posedge clk);
    s_axi_arvalid <= 1'b0;
    @(negedge clk);
    while (s_axi_rvalid !== 1'b1 && n++ < 99) @(negedge clk);
    if (n > 99) mismatches++;
    d = s_axi_rdata;
    check("rresp", er, s_axi_rresp);
    @(posedge clk);
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic t_regs;
    logic [31:0] d;
    rd(IDX_IOR1, RESP_OKAY, d);
    check("io1 reset", RST_IOR, d);
    rd(IDX_GRA, RESP_OKAY, d);
    check("gra reset", RST_GR, d);
    wr(IDX_IOR1, 32'h0);
    rd(IDX_IOR1, RESP_OKAY, d);
    check("io1 ones", ONES_IOR1, d);
    wr(10'h3FF, 32'h1, RESP_SLVERR);
    rd(10'h3FF, RESP_SLVERR, d);
    wr(IDX_CNT, 32'hA5C3);
    rd(IDX_CNT, RESP_OKAY, d);
    check("counter", 32'hA5C3, d);
    // Lane 0 only: the upper byte must survive
    wr(IDX_CNT, 32'h7711, RESP_OKAY, 4'h1);
    rd(IDX_CNT, RESP_OKAY, d);
    check("counter lane", 32'hA511, d);
    $display("regs done");
  endtask : t_regs
  task automatic t_cmp;
    logic [31:0] d, d2;
    logic e;
    wr(IDX_GRA, 32'h5);
    wr(IDX_GRA + 10'h1, 32'h5);
    wr(IDX_GRA + 10'h2, 32'h5);
    wr(IDX_GRA + 10'h3, 32'h5);
    for (int c = 0; c < 4; c++)
    begin
      wr(IDX_CNT, 32'h0);
      wr(IDX_IOR0, c | c << 4);
      wr(IDX_IOR1, c | c << 4);
      wr(IDX_CCR1, 32'h0F);
      check("init", 4'hF, pad);
      wr(IDX_MODE, 32'h80);
      repeat (20) @(posedge clk);
      wr(IDX_MODE, 32'h0);
      rd(IDX_CNT, RESP_OKAY, d);
      repeat (8) @(posedge clk);
      rd(IDX_CNT, RESP_OKAY, d2);
      check("cnt hold", d, d2);
      e = c == 0 || c == 2;
      check("pads", {4{e}}, pad);
      check("flags", 5'h0F, matchFlags);
      wr(IDX_STAT, 32'h0);
      @(negedge clk);
      check("flag clr", 5'h0, matchFlags);
    end
    $display("compare done");
  endtask : t_cmp
  task automatic t_pwm;
    int hb, hc, hd;
    logic [31:0] d;
    wr(IDX_CNT, 32'h0);
    wr(IDX_IOR0, 32'h1);
    wr(IDX_GRA, 32'd9);
    wr(IDX_GRA + 10'h1, 32'd3);
    wr(IDX_GRA + 10'h2, 32'd9);
    wr(IDX_GRA + 10'h3, 32'd3);
    wr(IDX_CCR1, 32'h08);
    wr(IDX_MODE, 32'h87);
    repeat (24) @(posedge clk);
    hb = 0;
    hc = 0;
    hd = 0;
    // Thirty samples span exactly three periods of ten
    repeat (30)
    begin
      @(negedge clk);
      hb += pad[1];
      hc += pad[2];
      hd += pad[3];
    end
    check("pwm b", 18, hb);
    check("pwm c", 0, hc);
    check("pwm d", 12, hd);
    check("pad a", 1, pad[0]);
    rd(IDX_CNT, RESP_OKAY, d);
    check("period", 1, d <= 9);
    wr(IDX_MODE, 32'h0);
    wr(IDX_CNT, 32'h0);
    wr(IDX_GRA, 32'h4);
    wr(IDX_CCR1, 32'h80);
    wr(IDX_MODE, 32'h80);
    repeat (9) @(posedge clk);
    rd(IDX_CNT, RESP_OKAY, d);
    check("clear", 1, d <= 4);
    wr(IDX_MODE, 32'h0);
    $display("pwm done");
  endtask : t_pwm
  task automatic t_src;
    int dv[8] = '{1, 2, 4, 8, 32, 4, 2, 0};
    int st, e;
    logic [31:0] d;
    for (int s = 0; s < 8; s++)
    begin
      wr(IDX_CNT, 32'h0);
      wr(IDX_CCR1, s << 4);
      wr(IDX_MODE, 32'h80);
      st = wrCyc;
      repeat (60) @(posedge clk);
      wr(IDX_MODE, 32'h0);
      rd(IDX_CNT, RESP_OKAY, d);
      // Free prescaler phase allows one tick either way
      e = dv[s] ? (wrCyc - st) / dv[s] : 0;
      check("src", 1, d + 1 >= e && d <= e + 1 && (dv[s] || d == 0));
    end
    $display("sources done");
  endtask : t_src
  task automatic t_buf;
    logic [31:0] d;
    wr(IDX_IOR0, 32'h33);
    wr(IDX_IOR1, 32'h00);
    wr(IDX_GRA, 32'h4);
    wr(IDX_GRA + 10'h1, 32'h4);
    wr(IDX_GRA + 10'h2, 32'h8);
    wr(IDX_GRA + 10'h3, 32'h8);
    wr(IDX_CNT, 32'h0);
    wr(IDX_CCR1, 32'h00);
    wr(IDX_MODE, 32'hB0);
    repeat (20) @(posedge clk);
    wr(IDX_MODE, 32'h0);
    // Second toggle only happens if the buffered value moved in
    check("buf pads", 4'hC, pad);
    rd(IDX_GRA, RESP_OKAY, d);
    check("buf gra", 32'h8, d);
    rd(IDX_GRA + 10'h1, RESP_OKAY, d);
    check("buf grb", 32'h8, d);
    $display("buffer done");
  endtask : t_buf
  task automatic t_ovf;
    logic [31:0] d;
    // Mode select set: pin A must stay released despite its action
    wr(IDX_IOR0, 32'h05);
    wr(IDX_CCR1, 32'h00);
    wr(IDX_CNT, 32'hFFF0);
    wr(IDX_MODE, 32'h80);
    repeat (30) @(posedge clk);
    wr(IDX_MODE, 32'h0);
    rd(IDX_CNT, RESP_OKAY, d);
    check("wrap", 1, d < 32'h40);
    check("ovf flag", 1, matchFlags[4]);
    check("mode a", 1, pad[0]);
    $display("overflow done");
  endtask : t_ovf
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial
  begin
    #2000000;
    mismatches++;
    final_report;
  end
  initial
  begin
    nrst = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    t_regs;
    t_cmp;
    t_pwm;
    t_src;
    t_buf;
    t_ovf;
    final_report;
  end
endmodule : cmp_pwm_top_test
